// >>> core/tsp_conv.sv
module tsp_conv
#(
   parameter int CONV_CYCLES = tsp_pkg::CONV_CYCLES_DEF
)
(
   // system clock
   input  wire logic clock,
   input  wire logic nrst,
   input  wire logic ce,
   // control
   input  wire logic run,
   // state
   output logic      busy,
   output logic      done
);
   import tsp_pkg::*;

   localparam int CW = $clog2(CONV_CYCLES + 1);

   if (CONV_CYCLES < 2)
   begin : g_chk
      $error("conversion length must be at least two cycles");
   end

   typedef struct packed
   {
      logic          busy;
      logic [CW-1:0] cnt;
   } tsp_conv_s;

   tsp_conv_s st_reg;
   tsp_conv_s st_next;

   always_comb
   begin
      st_next = st_reg;
      done    = 1'b0;
      if (st_reg.busy)
      begin
         if (st_reg.cnt == '0)
         begin
            // a running conversion always completes, whatever the mode
            st_next.busy = 1'b0;
            done         = 1'b1;
         end
         else
            st_next.cnt = st_reg.cnt - CW'(1);
      end
      else if (run)
      begin
         // continuous mode restarts as soon as the previous result is in
         st_next.busy = 1'b1;
         st_next.cnt  = CW'(CONV_CYCLES - 1);
      end
   end

   always_ff @(posedge clock)
   begin
      if (!nrst)
         st_reg <= '0;
      else if (ce)
         st_reg <= st_next;
   end

   assign busy = st_reg.busy;

endmodule : tsp_conv

// >>> core/tsp_pkg.sv
package tsp_pkg;

   // system clock and conversion timing
   localparam int CLK_HZ          = 25_000_000;
   localparam int CONV_TIME_MS    = 200;
   localparam int CONV_CYCLES_DEF = CONV_TIME_MS * (CLK_HZ / 1000);

   // frame layout on the link
   localparam int          WORD_BITS  = 16;
   localparam int          TEMP_BITS  = 14;
   localparam int          CMD_BITS   = 8;
   localparam logic [4:0]  PHASE_LAST = 5'h1f;
   localparam logic [4:0]  RX_FULL    = 5'h10;
   localparam logic [4:0]  CMD_MIN    = 5'h08;
   localparam logic [3:0]  BIT_TOP    = 4'hf;

   // word contents
   localparam logic [1:0]  LOW_ONES   = 2'h3;
   localparam logic [15:0] TX_RESET   = 16'h0003;
   // arbitrary identification value, not a real maker code
   localparam logic [15:0] ID_WORD_DEF = 16'h4a13;

   // command bytes
   localparam logic [7:0]  CODE_RUN   = 8'h00;
   localparam logic [7:0]  CODE_STOP  = 8'hff;

   typedef enum logic [1:0]
   {
      CMD_RUN  = 2'b00,
      CMD_STOP = 2'b01,
      CMD_TEST = 2'b10
   } tsp_cmd_e;

   // link side result handed to the system clock
   typedef struct packed
   {
      logic [7:0] cmd;
      logic [4:0] bits;
   } tsp_rx_s;

   // status levels shown at the top
   typedef struct packed
   {
      logic shutdown;
      logic result_valid;
      logic test_mode_seen;
   } tsp_status_s;

   function automatic tsp_cmd_e tsp_decode(input logic [7:0] code);
      tsp_cmd_e c;
      if (code == CODE_STOP)
         c = CMD_STOP;
      else if (code == CODE_RUN)
         c = CMD_RUN;
      else
         c = CMD_TEST;
      return c;
   endfunction : tsp_decode

endpackage : tsp_pkg

// >>> core/tsp_top.sv
module tsp_top
#(
   parameter int          CONV_CYCLES = tsp_pkg::CONV_CYCLES_DEF,
   // arbitrary identification value
   parameter logic [15:0] ID_WORD     = tsp_pkg::ID_WORD_DEF
)
(
   // system clock
   input  wire logic                 clock,
   input  wire logic                 nrst,
   input  wire logic                 ce,
   // serial link
   input  wire logic                 link_clock_in,
   input  wire logic                 link_select_n,
   input  wire logic                 sio_in,
   output logic                      sio_out,
   output logic                      sio_oe_n,
   // converter
   input  wire logic [13:0]          adc_code,
   // status
   output tsp_pkg::tsp_status_s      status
);
   import tsp_pkg::*;

   if (ID_WORD[1:0] != LOW_ONES)
   begin : g_chk
      $error("identification word must end in two ones");
   end

   // ---------------- link clock domain ----------------

   typedef struct packed
   {
      logic [4:0] phase;
      logic       ovr_valid;
      logic       ovr_stop;
   } tsp_frame_s;

   tsp_frame_s  fr_reg;
   tsp_frame_s  fr_next;
   tsp_rx_s     rx_reg;
   tsp_rx_s     rx_next;
   logic [4:0]  fall_reg;
   logic        stop_now;
   logic [15:0] word;

   // system state, declared here because the link reads two of its fields
   typedef struct packed
   {
      logic        sel_meta;
      logic        sel_sync;
      logic        sel_prev;
      logic        stop;
      logic [13:0] result;
      logic        have_result;
      logic        pending;
      logic [15:0] tx;
      logic        test_seen;
   } tsp_sys_s;

   tsp_sys_s st_reg;
   tsp_sys_s st_next;

   always_comb
   begin
      fr_next       = fr_reg;
      rx_next       = rx_reg;
      fr_next.phase = fr_reg.phase + 5'h01;
      if (!fr_reg.phase[4])
      begin
         if (fr_reg.phase == '0)
            rx_next.bits = '0;
      end
      else
      begin
         // receive phase: shift on the rising edge
         rx_next.cmd = {rx_reg.cmd[6:0], sio_in};
         if (rx_reg.bits < RX_FULL)
            rx_next.bits = rx_reg.bits + 5'h01;
         if (fr_reg.phase == PHASE_LAST)
         begin
            // a full receive phase with a run or stop code switches the mode within the frame; a test code leaves it as it was
            unique case (tsp_decode(rx_next.cmd))
               CMD_RUN:
               begin
                  fr_next.ovr_valid = 1'b1;
                  fr_next.ovr_stop  = 1'b0;
               end
               CMD_STOP:
               begin
                  fr_next.ovr_valid = 1'b1;
                  fr_next.ovr_stop  = 1'b1;
               end
               CMD_TEST:
               begin
                  fr_next.ovr_valid = fr_reg.ovr_valid;
               end
            endcase
         end
      end
   end

   // the frame counters clear as soon as select rises and stay clear while it is high, no clock needed
   always_ff @(posedge link_clock_in or posedge link_select_n)
   begin
      if (link_select_n)
         fr_reg <= '0;
      else
         fr_reg <= fr_next;
   end

   // received bits must outlive the frame so the system side can read them
   always_ff @(posedge link_clock_in)
   begin
      rx_reg <= rx_next;
   end

   always_ff @(negedge link_clock_in or posedge link_select_n)
   begin
      if (link_select_n)
         fall_reg <= '0;
      else
         fall_reg <= fall_reg + 5'h01;
   end

   // the system side holds tx and stop still while its synchronized select, sel_sync, is low
   assign stop_now = fr_reg.ovr_valid ? fr_reg.ovr_stop : st_reg.stop;
   assign word     = stop_now ? ID_WORD : st_reg.tx;

   // pin levels are a mux on flops so bit 15 appears at select fall
   assign sio_out  = word[BIT_TOP - fall_reg[3:0]];
   assign sio_oe_n = link_select_n | fall_reg[4];

   // ---------------- system clock domain ----------------

   logic     conv_busy;
   logic     conv_done;
   logic     frame_end;
   logic     in_frame;
   tsp_cmd_e cmd;

   tsp_conv
   #(
      .CONV_CYCLES (CONV_CYCLES)
   )
   u_conv
   (
      .clock (clock),
      .nrst  (nrst),
      .ce    (ce),
      .run   (!st_reg.stop),
      .busy  (conv_busy),
      .done  (conv_done)
   );

   assign in_frame  = !st_reg.sel_sync;
   assign frame_end = st_reg.sel_sync && !st_reg.sel_prev;
   // only the low byte counts, the upper command byte is dropped
   assign cmd       = tsp_decode(rx_reg.cmd);

   always_comb
   begin
      st_next          = st_reg;
      st_next.sel_meta = link_select_n;
      st_next.sel_sync = st_reg.sel_meta;
      st_next.sel_prev = st_reg.sel_sync;

      if (conv_done)
      begin
         st_next.result      = adc_code;
         st_next.have_result = 1'b1;
         if (in_frame)
            st_next.pending = 1'b1;
         else
            st_next.tx = {adc_code, LOW_ONES};
      end

      if (frame_end)
      begin
         // link flops are quiet now: select is high and the clock idles
         if (rx_reg.bits >= CMD_MIN)
         begin
            unique case (cmd)
               CMD_RUN:
                  st_next.stop = 1'b0;
               CMD_STOP:
                  st_next.stop = 1'b1;
               CMD_TEST:
                  st_next.test_seen = 1'b1;
            endcase
         end
         if (st_reg.pending || conv_done)
         begin
            st_next.pending = 1'b0;
            st_next.tx      = {conv_done ? adc_code : st_reg.result, LOW_ONES};
         end
      end
   end

   always_ff @(posedge clock)
   begin
      if (!nrst)
      begin
         st_reg          <= '0;
         st_reg.sel_meta <= 1'b1;
         st_reg.sel_sync <= 1'b1;
         st_reg.sel_prev <= 1'b1;
         st_reg.tx       <= TX_RESET;
      end
      else if (ce)
         st_reg <= st_next;
   end

   assign status.shutdown       = st_reg.stop;
   assign status.result_valid   = st_reg.have_result;
   assign status.test_mode_seen = st_reg.test_seen;

endmodule : tsp_top

// >>> verification/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import tsp_pkg::*;
   localparam int          CONV = 20;
   // arbitrary identification value
   localparam logic [15:0] ID   = 16'h5c2f;
   logic        clock;
   logic        nrst;
   logic        ce;
   logic [13:0] adc_code;
   logic        link_clock_in, link_select_n, sio_in, sio_out, sio_oe_n;
   tsp_status_s status;
   logic [31:0] rd;
   logic [13:0] codes [3] = '{14'h12c0, 14'h3fff, 14'h3b00};
   int          mismatches = 0;
   int          comparisons = 0;

   tsp_top #(.CONV_CYCLES(CONV), .ID_WORD(ID)) dut_u (.clock, .nrst, .ce, .link_clock_in,
      .link_select_n, .sio_in, .sio_out, .sio_oe_n, .adc_code, .status);
   tsp_master m_u (.link_clock_in, .link_select_n, .sio_in, .sio_out, .sio_oe_n);

   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp)
      begin
         mismatches++;
         $display("MISMATCH %s exp %h got %h", what, exp, got);
      end
   endtask : check

   task automatic stat(input logic [2:0] exp);
      repeat (4) @(negedge clock);
      check("status", {13'h0, exp}, {13'h0, status});
   endtask : stat

   // long enough for two whole conversions with the new code
   task automatic settle(input logic [13:0] a);
      adc_code = a;
      repeat (2 * CONV + 8) @(negedge clock);
   endtask : settle

   task automatic wrap_up;
      $display("mismatches %0d comparisons %0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : wrap_up

   initial
   begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   initial
   begin
      #1ms;
      mismatches++;
      wrap_up();
   end

   initial
   begin
      nrst = 1'b0;
      ce = 1'b1;
      adc_code = 14'h0c80;
      repeat (8) @(negedge clock);
      nrst = 1'b1;
      repeat (3) @(negedge clock);
      m_u.xfer(16, 32'h0, rd);
      check("first", TX_RESET, rd[15:0]);
      stat(3'b010);
      foreach (codes[i])
      begin
         settle(codes[i]);
         m_u.xfer(32, 32'h0, rd);
         check("temp", {codes[i], LOW_ONES}, rd[15:0]);
      end
      m_u.xfer(5, 32'h0, rd);
      check("short", {11'h0, codes[2][13:9]}, rd[15:0]);
      m_u.xfer(16, 32'h0, rd);
      check("reread", {codes[2], LOW_ONES}, rd[15:0]);
      settle(14'h0321);
      m_u.xfer(64, {16'ha5ff, 16'h0000}, rd);
      check("chain temp", {14'h0321, LOW_ONES}, rd[31:16]);
      check("chain id", ID, rd[15:0]);
      stat(3'b010);
      m_u.xfer(32, {16'h33ff, 16'h0000}, rd);
      stat(3'b110);
      settle(14'h0155);
      m_u.xfer(24, 32'h0, rd);
      check("id", ID, rd[15:0]);
      stat(3'b010);
      settle(14'h0155);
      m_u.xfer(16, 32'h0, rd);
      check("resumed", {14'h0155, LOW_ONES}, rd[15:0]);
      // clock enable low freezes conversions, so the old word must stay
      ce = 1'b0;
      settle(14'h0aaa);
      m_u.xfer(16, 32'h0, rd);
      check("frozen", {14'h0155, LOW_ONES}, rd[15:0]);
      ce = 1'b1;
      repeat (4) @(negedge clock);
      m_u.xfer(32, {16'h005a, 16'h0000}, rd);
      stat(3'b011);
      wrap_up();
   end
endmodule : testbench

// >>> verification/tsp_master.sv
module tsp_master
(
   // link toward the device
   output logic      link_clock_in,
   output logic      link_select_n,
   output logic      sio_in,
   // device pin drive
   input  wire logic sio_out,
   input  wire logic sio_oe_n
);
   timeunit 1ns;
   timeprecision 100ps;
   logic m_oe = 1'b0;
   logic m_d  = 1'b0;
   // a released pin reads the inverse of the last bit, never a stale copy
   assign sio_in = !sio_oe_n ? sio_out : (m_oe ? m_d : !m_d);
   initial
   begin
      link_clock_in = 1'b0;
      link_select_n = 1'b1;
   end
   // clock idles low between frames; phases repeat every 32 clocks
   task automatic xfer(input int n, input logic [31:0] w, output logic [31:0] r);
      r = 32'h0;
      link_select_n = 1'b0;
      #90;
      for (int k = 0; k < n; k++)
      begin
         m_oe = (k % 32 >= 16);
         if (m_oe)
         begin
            m_d = w[31];
            w   = w << 1;
         end
         #30 link_clock_in = 1'b1;
         if (!m_oe)
            r = {r[30:0], sio_in};
         #62.5 link_clock_in = 1'b0;
         #32.5;
      end
      link_select_n = 1'b1;
      m_oe = 1'b0;
      #200;
   endtask : xfer
endmodule : tsp_master

// >>> verification/tsp_top_props.sv
module tsp_top_props
#(
   parameter int          CONV_CYCLES = 20,
   parameter logic [15:0] ID_WORD     = 16'h0003
)
(
   // system clock
   input wire logic                 clock,
   input wire logic                 nrst,
   // serial link
   input wire logic                 link_clock_in,
   input wire logic                 link_select_n,
   input wire logic                 sio_out,
   input wire logic                 sio_oe_n,
   // status
   input wire tsp_pkg::tsp_status_s status
);
   timeunit 1ns;
   timeprecision 100ps;
   import tsp_pkg::*;
   logic [4:0] fall_cnt;
   int         wait_cnt;
   // frame position; select high clears it with no clock running
   always_ff @(negedge link_clock_in or posedge link_select_n)
      if (link_select_n)
         fall_cnt <= 5'h00;
      else
         fall_cnt <= fall_cnt + 5'h01;
   always_ff @(posedge clock)
      if (!nrst || status.result_valid)
         wait_cnt <= 0;
      else
         wait_cnt <= wait_cnt + 1;
   chk_reset_state: assert property (@(posedge clock) disable iff (!nrst)
      $rose(nrst) |-> status == 3'h0) else $error("status not reset");
   chk_first_result: assert property (@(posedge clock) disable iff (!nrst)
      wait_cnt <= CONV_CYCLES + 4) else $error("conversion late");
   chk_pin_idle: assert property (@(posedge clock) disable iff (!nrst)
      link_select_n |-> sio_oe_n) else $error("pin driven idle");
   chk_bit_hold: assert property (@(posedge clock) disable iff (!nrst)
      link_clock_in && $past(link_clock_in) && !link_select_n && !$past(link_select_n) && !sio_oe_n
      |-> $stable(sio_out)) else $error("bit moved while clock high");
   chk_mode_quiet: assert property (@(posedge clock) disable iff (!nrst)
      $changed(status.shutdown) |-> link_select_n) else $error("mode changed in frame");
   chk_phase_drive: assert property (@(posedge link_clock_in) disable iff (link_select_n)
      sio_oe_n == fall_cnt[4]) else $error("drive phase wrong");
   chk_low_ones: assert property (@(posedge link_clock_in) disable iff (link_select_n)
      fall_cnt[4:1] == 4'h7 |-> sio_out) else $error("low bits not one");
   chk_id_bits: assert property (@(posedge link_clock_in) disable iff (link_select_n)
      status.shutdown && !fall_cnt[4] |-> sio_out == ID_WORD[4'hf - fall_cnt[3:0]])
      else $error("id bit wrong");
endmodule : tsp_top_props

bind tsp_top tsp_top_props #(.CONV_CYCLES(CONV_CYCLES), .ID_WORD(ID_WORD)) chk_u (.clock, .nrst,
   .link_clock_in, .link_select_n, .sio_out, .sio_oe_n, .status);
